// ---- src/dtc_ctrl.sv ----
// Day-tank fill, manual transfer, pump selection and alarm indication controller.
//==========================================================================
// Contract
// (R01) Auto mode starts a day-tank fill when its level falls to the trigger.
// (R02) Stop during a transfer halts it and puts the day tank in manual; the code does so only when the day tank is the destination.
// (R03) Manual returns to auto once day level rises above the trigger.
// (R04) Restore command forces auto mode and returns display to main view.
// (R05) Alternating mode swaps first and second supply on each fill.
// (R06) Otherwise draw from first supply until empty, then the second.
// (R07) First and second supply may be the same tank.
// (R08) Bell flashes for the displayed alarming tank, steady for another.
// (R09) Mute silences the audible alarm.
// (R10) Solenoid without current stops the transfer and flags a solenoid fault.
// (R11) Pump without current, sensing enabled, stops transfer and flags pump fault.
// (R12) Small tank bell shown only while that tank's alarm is enabled.
// (R13) Tank alarm is empty or full depending on tank type.
// (R14) Silent or unpowered configured tank shows link loss until it recovers.
// (R15) Enter in monitoring toggles single-tank and all-tanks views.
// (R16) Type 4 is fuel, 5 is day tank; only type 5 auto-fills.
// (R17) With a special tank, manual transfers always go to it.
// (R18) Manual transfers stay available alongside day-tank auto fill.
// (R19) Pump stops when the destination reaches its pump-off level.
// (R20) Leaving setup commits settings and enters monitoring mode.
// (R21) Levels are bar steps, 0 empty and 16 full.
// (R22) Each remote unit has a unique address from 2 to 9.
// (R23) Pump uses the primary unit, else the secondary if absent or faulty.
// (R24) Pump and valves energised only while a transfer runs.
//==========================================================================
`timescale 1ns/1ps
`include "dtc_defs.svh"
module dtc_ctrl
  import dtc_pkg::*;
#(
  parameter int SETTLE_CYC = `DTC_SETTLE_US * `DTC_CLK_MHZ,
  parameter int BLINK_CYC  = `DTC_BLINK_MS * 1000 * `DTC_CLK_MHZ
)(
  // Clock and reset.
  input  wire logic                                      ref_clk_i,
  input  wire logic                                      arst_n_i,
  // Setup.
  input  wire dtc_cfg_t                                  cfg_i,
  input  wire logic                                      setup_enter_i,
  input  wire logic                                      setup_exit_i,
  // Remote unit reports.
  input  wire logic [`DTC_N_TANK-1:0][`DTC_LVL_W-1:0]    level_i,
  input  wire logic [`DTC_N_TANK-1:0]                    link_ok_i,
  input  wire logic [`DTC_N_TANK-1:0]                    sol_sense_i,
  input  wire logic [1:0]                                pump_present_i,
  input  wire logic [1:0]                                pump_sense_i,
  // Operator keys.
  input  wire logic                                      enter_key_i,
  input  wire logic                                      mute_key_i,
  input  wire logic                                      stop_key_i,
  input  wire logic                                      restore_auto_i,
  input  wire logic                                      xfer_start_i,
  input  wire logic [2:0]                                xfer_src_i,
  input  wire logic [2:0]                                xfer_dst_i,
  input  wire logic [2:0]                                disp_slot_i,
  // Actuators.
  output logic [`DTC_N_TANK-1:0]                         valve_out_o,
  output logic [`DTC_N_TANK-1:0]                         valve_in_o,
  output logic [1:0]                                     pump_on_o,
  // Status and indication.
  output logic                                           program_mode_o,
  output logic                                           day_auto_o,
  output logic                                           xfer_active_o,
  output logic                                           disp_all_o,
  output logic                                           bell_o,
  output logic                                           audible_o,
  output logic                                           sol_fault_o,
  output logic                                           pump_fault_o,
  output logic [`DTC_N_TANK-1:0]                         small_bell_o,
  output logic [`DTC_N_TANK-1:0]                         tank_alarm_o,
  output logic [`DTC_N_TANK-1:0]                         link_loss_indication_o
);

  localparam logic [31:0] SETTLE_LAST = 32'(SETTLE_CYC - 1);
  localparam logic [31:0] BLINK_LAST  = 32'(BLINK_CYC - 1);

  //========================================================================
  // State.
  dtc_cfg_t                        cfg_r;
  dtc_xf_state_t                   st_r;
  dtc_xf_state_t                   st_nxt;
  logic [31:0]                     cnt_r;
  logic [31:0]                     blink_cnt_r;
  logic                            blink_r;
  logic [2:0]                      src_r;
  logic [2:0]                      src_nxt;
  logic [2:0]                      dst_r;
  logic [2:0]                      dst_nxt;
  logic                            sec_r;
  logic                            sec_nxt;
  logic                            alt_sel_r;
  logic                            auto_r;
  logic                            prog_r;
  logic                            mute_r;
  logic                            sol_fault_r;
  logic                            pump_fault_r;
  logic [2:0]                      fault_slot_r;
  logic [`DTC_N_TANK-1:0]          alarm_w;

  //========================================================================
  // Decode.
  wire [2:0]             day_slot  = cfg_r.day_slot;
  wire [`DTC_LVL_W-1:0]  day_lvl   = level_i[day_slot];
  wire                   monitor   = ~prog_r;
  wire                   day_cfg   = cfg_r.tank[day_slot].present &&
                                     cfg_r.tank[day_slot].ttype == `DTC_TYPE_DAY; // [R16]
  wire                   day_low   = day_lvl <= cfg_r.trig_lvl;
  wire                   pref1_dry = level_i[cfg_r.pref1_slot] == `DTC_LVL_EMPTY; // [R21]
  // Same slot for both supplies simply selects one tank either way.
  wire [2:0]             auto_src  = cfg_r.alt_mode ?
                                     (alt_sel_r ? cfg_r.pref2_slot : cfg_r.pref1_slot) : // [R05] [R07]
                                     (pref1_dry ? cfg_r.pref2_slot : cfg_r.pref1_slot);  // [R06]
  wire                   idle      = st_r == XF_IDLE;
  wire                   active    = ~idle;
  wire                   auto_go   = monitor && day_cfg && auto_r && day_low && idle &&
                                     level_i[auto_src] != `DTC_LVL_EMPTY; // [R01]
  wire                   man_go    = monitor && xfer_start_i && idle && ~auto_go; // [R18]
  wire [2:0]             man_dst   = cfg_r.special_en ? cfg_r.special_slot : xfer_dst_i; // [R17]
  // Every new pump start tries the primary unit again whenever it is on the network.
  wire                   pri_ok    = pump_present_i[0]; // [R23]
  wire [`DTC_LVL_W-1:0]  dst_lvl   = level_i[dst_r];
  wire                   done      = level_i[src_r] == `DTC_LVL_EMPTY ||
                                     dst_lvl >= `DTC_LVL_FULL ||
                                     dst_lvl >= cfg_r.tank[dst_r].off_lvl; // [R19]
  wire                   halt      = active && (stop_key_i || done);
  wire                   sol_bad   = (st_r == XF_RUN) &&
                                     (~sol_sense_i[src_r] || ~sol_sense_i[dst_r]); // [R10]
  wire                   pump_bad  = (st_r == XF_RUN) && cfg_r.pump_sense_en[sec_r] &&
                                     ~pump_sense_i[sec_r]; // [R11]
  wire                   pump_swap = pump_bad && ~sec_r && pump_present_i[1]; // [R23]
  wire                   pump_dead = pump_bad && ~pump_swap;
  wire                   any_alarm = |alarm_w || sol_fault_r || pump_fault_r;
  wire                   disp_hit  = alarm_w[disp_slot_i] ||
                                     ((sol_fault_r || pump_fault_r) && fault_slot_r == disp_slot_i);

  //========================================================================
  // Tank alarm conditions.
  always_comb
  begin
    for (int i = 0; i < `DTC_N_TANK; i++)
    begin
      if (cfg_r.tank[i].ttype == `DTC_TYPE_FUEL || cfg_r.tank[i].ttype == `DTC_TYPE_DAY)
        alarm_w[i] = cfg_r.tank[i].present && cfg_r.tank[i].alarm_en &&
                     level_i[i] <= cfg_r.tank[i].alarm_lvl; // [R13]
      else
        alarm_w[i] = cfg_r.tank[i].present && cfg_r.tank[i].alarm_en &&
                     level_i[i] >= cfg_r.tank[i].alarm_lvl; // [R13]
    end
  end

  //========================================================================
  // Transfer sequencing.
  always_comb
  begin
    st_nxt  = st_r;
    src_nxt = src_r;
    dst_nxt = dst_r;
    sec_nxt = sec_r;
    case (st_r)
      XF_IDLE:
      begin
        if (auto_go)
        begin
          st_nxt  = XF_SETTLE;
          src_nxt = auto_src;
          dst_nxt = day_slot;
          sec_nxt = ~pri_ok; // [R23]
        end
        else if (man_go)
        begin
          st_nxt  = XF_SETTLE;
          src_nxt = xfer_src_i;
          dst_nxt = man_dst;
          sec_nxt = ~pri_ok; // [R23]
        end
      end
      XF_SETTLE:
      begin
        if (halt)
          st_nxt = XF_IDLE;
        else if (cnt_r == SETTLE_LAST)
          st_nxt = XF_RUN;
      end
      XF_RUN:
      begin
        if (halt || sol_bad || pump_dead)
          st_nxt = XF_IDLE; // [R10] [R11]
        else if (pump_swap)
        begin
          st_nxt  = XF_SETTLE;
          sec_nxt = 1'b1; // [R23]
        end
      end
      default:
        st_nxt = XF_IDLE;
    endcase
  end

  //========================================================================
  // Sequencer registers.
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_r  <= XF_IDLE;
      cnt_r <= 32'h0;
      src_r <= 3'h0;
      dst_r <= 3'h0;
      sec_r <= 1'b0;
    end
    else
    begin
      st_r  <= st_nxt;
      cnt_r <= (st_nxt == XF_SETTLE && st_r == XF_SETTLE) ? cnt_r + 32'h1 : 32'h0;
      src_r <= src_nxt;
      dst_r <= dst_nxt;
      sec_r <= sec_nxt;
    end
  end

  //========================================================================
  // Actuators follow the sequencer; all drop together on stop or fault.
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      valve_out_o   <= '0;
      valve_in_o    <= '0;
      pump_on_o     <= 2'h0;
      xfer_active_o <= 1'b0;
    end
    else
    begin
      valve_out_o   <= (st_nxt != XF_IDLE) ? (`DTC_N_TANK'(1) << src_nxt) : '0; // [R24]
      valve_in_o    <= (st_nxt != XF_IDLE) ? (`DTC_N_TANK'(1) << dst_nxt) : '0; // [R24]
      pump_on_o     <= (st_nxt != XF_IDLE) ? (sec_nxt ? 2'h2 : 2'h1) : 2'h0;   // [R24] [R23]
      xfer_active_o <= st_nxt != XF_IDLE;
    end
  end

  //========================================================================
  // Configuration, modes and fault flags.
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cfg_r        <= '0;
      prog_r       <= 1'b1;
      auto_r       <= 1'b1;
      alt_sel_r    <= 1'b0;
      sol_fault_r  <= 1'b0;
      pump_fault_r <= 1'b0;
      fault_slot_r <= 3'h0;
      disp_all_o   <= 1'b0;
    end
    else
    begin
      if (prog_r && setup_exit_i)
      begin
        cfg_r  <= cfg_i; // [R20]
        prog_r <= 1'b0;  // [R20]
      end
      else if (monitor && setup_enter_i && idle)
        prog_r <= 1'b1;
      if (restore_auto_i)
        auto_r <= 1'b1; // [R04]
      else if (stop_key_i && active && dst_r == day_slot)
        auto_r <= 1'b0; // [R02]
      else if (!auto_r && !day_low)
        auto_r <= 1'b1; // [R03]
      if (auto_go)
        alt_sel_r <= ~alt_sel_r; // [R05]
      if (sol_bad)
        sol_fault_r <= 1'b1; // [R10]
      else if (restore_auto_i || man_go)
        sol_fault_r <= 1'b0;
      if (pump_dead)
        pump_fault_r <= 1'b1; // [R11]
      else if (restore_auto_i || man_go)
        pump_fault_r <= 1'b0;
      if (sol_bad)
        fault_slot_r <= sol_sense_i[src_r] ? dst_r : src_r;
      else if (pump_dead)
        fault_slot_r <= dst_r;
      if (restore_auto_i)
        disp_all_o <= 1'b0; // [R04]
      else if (monitor && enter_key_i)
        disp_all_o <= ~disp_all_o; // [R15]
    end
  end

  //========================================================================
  // Bell, mute and display indicators.
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      blink_cnt_r            <= 32'h0;
      blink_r                <= 1'b0;
      mute_r                 <= 1'b0;
      bell_o                 <= 1'b0;
      audible_o              <= 1'b0;
      small_bell_o           <= '0;
      tank_alarm_o           <= '0;
      link_loss_indication_o <= '0;
    end
    else
    begin
      blink_cnt_r <= (blink_cnt_r >= BLINK_LAST) ? 32'h0 : blink_cnt_r + 32'h1;
      if (blink_cnt_r >= BLINK_LAST)
        blink_r <= ~blink_r;
      if (mute_key_i && any_alarm)
        mute_r <= 1'b1; // [R09]
      else if (!any_alarm)
        mute_r <= 1'b0;
      bell_o    <= any_alarm && (disp_hit ? blink_r : 1'b1); // [R08]
      audible_o <= any_alarm && !mute_r && !mute_key_i;      // [R09]
      for (int i = 0; i < `DTC_N_TANK; i++)
      begin
        small_bell_o[i]           <= cfg_r.tank[i].present && cfg_r.tank[i].alarm_en; // [R12]
        link_loss_indication_o[i] <= cfg_r.tank[i].present && !link_ok_i[i];        // [R14]
      end
      tank_alarm_o <= alarm_w;
    end
  end

  //========================================================================
  // Plain status outputs.
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      program_mode_o <= 1'b1;
      day_auto_o     <= 1'b1;
      sol_fault_o    <= 1'b0;
      pump_fault_o   <= 1'b0;
    end
    else
    begin
      program_mode_o <= prog_r;
      day_auto_o     <= auto_r;
      sol_fault_o    <= sol_fault_r;
      pump_fault_o   <= pump_fault_r;
    end
  end

endmodule

// ---- src/dtc_defs.svh ----
// Constants for the day-tank transfer and alarm controller.
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH
`define DTC_N_TANK     8
`define DTC_ADDR_BASE  4'h2
`define DTC_LVL_W      5
`define DTC_LVL_EMPTY  5'h00
`define DTC_LVL_FULL   5'h10
`define DTC_TYPE_GREY  3'h1
`define DTC_TYPE_BLACK 3'h2
`define DTC_TYPE_WATER 3'h3
`define DTC_TYPE_FUEL  3'h4
`define DTC_TYPE_DAY   3'h5
`define DTC_CLK_MHZ    200
`define DTC_SETTLE_US  50
`define DTC_BLINK_MS   250
`endif

// ---- src/dtc_pkg.sv ----
// Types shared by the day-tank transfer and alarm controller.
`include "dtc_defs.svh"
package dtc_pkg;
  typedef struct packed {
    logic                  present;
    logic [2:0]            ttype;
    logic                  alarm_en;
    logic [`DTC_LVL_W-1:0] alarm_lvl;
    logic [`DTC_LVL_W-1:0] off_lvl;
  } dtc_tank_cfg_t;

  typedef struct packed {
    dtc_tank_cfg_t [`DTC_N_TANK-1:0] tank;
    logic [2:0]                      day_slot;
    logic [2:0]                      pref1_slot;
    logic [2:0]                      pref2_slot;
    logic [`DTC_LVL_W-1:0]           trig_lvl;
    logic                            alt_mode;
    logic                            special_en;
    logic [2:0]                      special_slot;
    logic [1:0]                      pump_sense_en;
  } dtc_cfg_t;

  typedef enum logic [1:0] {
    XF_IDLE   = 2'b00,
    XF_SETTLE = 2'b01,
    XF_RUN    = 2'b10
  } dtc_xf_state_t;
endpackage

// ---- tb/dtc_ctrl_asserts.sv ----
// Port-level assertions for the day-tank transfer and alarm controller.
`timescale 1ns/1ps
module dtc_ctrl_asserts
  import dtc_pkg::*;
(
  // Clock and reset.
  input wire logic       ref_clk_i,
  input wire logic       arst_n_i,
  // Keys and unit status.
  input wire logic       setup_exit_i,
  input wire logic       enter_key_i,
  input wire logic       mute_key_i,
  input wire logic       stop_key_i,
  input wire logic       restore_auto_i,
  input wire logic [1:0] pump_present_i,
  // Controller outputs.
  input wire logic [7:0] valve_out_o,
  input wire logic [7:0] valve_in_o,
  input wire logic [1:0] pump_on_o,
  input wire logic       program_mode_o,
  input wire logic       day_auto_o,
  input wire logic       xfer_active_o,
  input wire logic       disp_all_o,
  input wire logic       audible_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  //==========================================================================
  // Checks.
  a_setup_exit: assert property (program_mode_o && setup_exit_i |-> ##[2:3] !program_mode_o)
    else $error("setup exit ignored");
  a_stop_halt: assert property (stop_key_i && xfer_active_o |-> ##[1:2] (!xfer_active_o && !pump_on_o))
    else $error("stop did not halt transfer");
  a_idle_quiet: assert property (!xfer_active_o |-> {valve_out_o, valve_in_o, pump_on_o} == 18'h0)
    else $error("actuator on while idle");
  a_start_valves: assert property ($rose(xfer_active_o) |->
    $onehot(valve_out_o) && $onehot(valve_in_o) && valve_out_o != valve_in_o) else $error("bad valve pick");
  a_pump_primary: assert property ($rose(xfer_active_o) && pump_present_i[0] |-> pump_on_o == 2'b01)
    else $error("primary pump not used");
  a_mute_silence: assert property (mute_key_i && !program_mode_o |-> ##[1:2] !audible_o)
    else $error("mute ignored");
  a_enter_toggle: assert property (enter_key_i && !program_mode_o && !restore_auto_i |=>
    ##1 disp_all_o != $past(disp_all_o, 2)) else $error("view did not toggle");
  a_restore_auto: assert property (restore_auto_i && !program_mode_o |-> ##[1:2] (day_auto_o && !disp_all_o))
    else $error("restore ignored");
endmodule

bind dtc_ctrl dtc_ctrl_asserts u_chk (.*);

// ---- tb/dtc_far_model.sv ----
// Behavioural model of the remote tank and pump units.
`timescale 1ns/1ps
module dtc_far_model
  import dtc_pkg::*;
(
  // Controller commands.
  input  wire logic [7:0]      valve_out_i,
  input  wire logic [7:0]      valve_in_i,
  input  wire logic [1:0]      pump_on_i,
  // Plant state from the bench.
  input  wire logic [7:0][4:0] lvl_i,
  input  wire logic [7:0]      alive_i,
  input  wire logic [7:0]      sol_bad_i,
  input  wire logic [1:0]      pump_bad_i,
  // Unit reports.
  output logic [7:0][4:0]      level_o,
  output logic [7:0]           link_ok_o,
  output logic [7:0]           sol_sense_o,
  output logic [1:0]           pump_present_o,
  output logic [1:0]           pump_sense_o
);
  // Slot i is the unit at address 2+i; a silent unit reads back garbage, not its last level.
  for (genvar i = 0; i < 8; i++)
  begin
    assign level_o[i] = alive_i[i] ? lvl_i[i] : ~lvl_i[i];
  end
  assign link_ok_o      = alive_i;
  assign sol_sense_o    = (valve_out_i | valve_in_i) & ~sol_bad_i & alive_i;
  assign pump_present_o = 2'b11;
  assign pump_sense_o   = pump_on_i & ~pump_bad_i;
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the day-tank transfer and alarm controller.
`timescale 1ns/1ps
`include "dtc_defs.svh"
module tb_top
  import dtc_pkg::*;
;
  localparam int SEN = 0, SEX = 1, ENT = 2, MUT = 3, STP = 4, RES = 5, STA = 6;
  typedef struct packed { logic [2:0] s, d; logic [7:0] vo, vi; } dtc_row_t;
  dtc_row_t        rows [2] = '{'{3'h1, 3'h3, 8'h02, 8'h08}, '{3'h3, 3'h2, 8'h08, 8'h04}};
  logic            clk = 1'b0;
  logic            rst_n = 1'b0;
  logic [6:0]      key = '0;
  logic [2:0]      src = '0, dst = '0, disp = '0;
  logic [1:0]      pump_bad = '0, pump_present, pump_sense, pump_on;
  logic [7:0]      alive = '1, sol_bad = '0, link_ok, sol_sense, vout, vin, sbell, talarm, lloss;
  logic [7:0][4:0] lvl, level;
  dtc_cfg_t        cfg = '0;
  logic            prog, dauto, active, dall, bell, aud, sfault, pfault;
  int              err_count = 0, compares = 0, ones;

  dtc_ctrl #(.SETTLE_CYC(4), .BLINK_CYC(8)) DUT (
    .ref_clk_i(clk), .arst_n_i(rst_n), .cfg_i(cfg), .setup_enter_i(key[SEN]), .setup_exit_i(key[SEX]),
    .level_i(level), .link_ok_i(link_ok), .sol_sense_i(sol_sense), .pump_present_i(pump_present),
    .pump_sense_i(pump_sense), .enter_key_i(key[ENT]), .mute_key_i(key[MUT]), .stop_key_i(key[STP]),
    .restore_auto_i(key[RES]), .xfer_start_i(key[STA]), .xfer_src_i(src), .xfer_dst_i(dst), .disp_slot_i(disp),
    .valve_out_o(vout), .valve_in_o(vin), .pump_on_o(pump_on), .program_mode_o(prog), .day_auto_o(dauto),
    .xfer_active_o(active), .disp_all_o(dall), .bell_o(bell), .audible_o(aud), .sol_fault_o(sfault),
    .pump_fault_o(pfault), .small_bell_o(sbell), .tank_alarm_o(talarm), .link_loss_indication_o(lloss));

  dtc_far_model u_far (.valve_out_i(vout), .valve_in_i(vin), .pump_on_i(pump_on), .lvl_i(lvl), .alive_i(alive),
    .sol_bad_i(sol_bad), .pump_bad_i(pump_bad), .level_o(level), .link_ok_o(link_ok), .sol_sense_o(sol_sense),
    .pump_present_o(pump_present), .pump_sense_o(pump_sense));

  always #2.5 clk = ~clk;

  //==========================================================================
  // Helpers.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_on(input logic w, input int n);
    for (int i = 0; i < n && active !== w; i++)
      step(1);
  endtask

  task automatic press(input int b);
    @(posedge clk) key[b] <= 1'b1;
    @(posedge clk) key[b] <= 1'b0;
    step(3);
  endtask

  task automatic start(input logic [2:0] s, input logic [2:0] d);
    @(posedge clk)
    begin
      src <= s;
      dst <= d;
      key[STA] <= 1'b1;
    end
    @(posedge clk) key[STA] <= 1'b0;
    wait_on(1'b1, 8);
  endtask

  task automatic count_bell();
    ones = 0;
    repeat (40)
    begin
      step(1);
      ones += (bell === 1'b1);
    end
  endtask

  task automatic complete_run();
    if (err_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  //==========================================================================
  // Main sequence.
  initial
  begin
    lvl = {8{5'h08}};
    lvl[0] = 5'h0a;
    cfg.tank[0] = '{1'b1, `DTC_TYPE_DAY, 1'b0, 5'h00, `DTC_LVL_FULL};
    cfg.tank[1] = '{1'b1, `DTC_TYPE_FUEL, 1'b1, 5'h02, `DTC_LVL_FULL};
    cfg.tank[2] = '{1'b1, `DTC_TYPE_FUEL, 1'b0, 5'h00, `DTC_LVL_FULL};
    cfg.tank[3] = '{1'b1, `DTC_TYPE_FUEL, 1'b0, 5'h00, 5'h0c};
    cfg.tank[4] = '{1'b1, `DTC_TYPE_WATER, 1'b1, 5'h0c, `DTC_LVL_FULL};
    cfg.pref1_slot = 3'h1;
    cfg.pref2_slot = 3'h2;
    cfg.trig_lvl = 5'h04;
    cfg.alt_mode = 1'b1;
    cfg.pump_sense_en = 2'b11;
    step(15);
    chk("reset_state", 3'b110, {prog, dauto, active});
    @(posedge clk) rst_n <= 1'b1;
    press(SEX);
    chk("program_mode", 0, prog);
    foreach (rows[r])
    begin
      start(rows[r].s, rows[r].d);
      chk("valves", {rows[r].vo, rows[r].vi, 2'b01}, {vout, vin, pump_on});
      press(STP);
      wait_on(1'b0, 8);
      chk("stopped", 19'h1, {vout, vin, pump_on, dauto});
    end
    start(3'h1, 3'h3);
    @(posedge clk) lvl[3] <= 5'h0c;
    wait_on(1'b0, 8);
    chk("pump_off_level", 0, {active, pump_on});
    @(posedge clk) lvl[3] <= 5'h08;
    @(posedge clk) lvl[0] <= 5'h04;
    wait_on(1'b1, 8);
    chk("auto_fill", 16'h0201, {vout, vin});
    press(ENT);
    chk("view_all", 1, dall);
    press(STP);
    step(4);
    chk("manual", 0, {dauto, active});
    @(posedge clk) lvl[0] <= 5'h05;
    step(3);
    chk("auto_again", 1, dauto);
    @(posedge clk) lvl[0] <= 5'h04;
    wait_on(1'b1, 8);
    chk("alt_src", 8'h04, vout);
    press(STP);
    press(RES);
    chk("restored", 2'b10, {dauto, dall});
    wait_on(1'b1, 8);
    chk("alt_back", 8'h02, vout);
    @(posedge clk) lvl[0] <= 5'h10;
    wait_on(1'b0, 8);
    @(posedge clk) sol_bad[3] <= 1'b1;
    start(3'h1, 3'h3);
    wait_on(1'b0, 20);
    step(3);
    chk("sol_fault", 20'h80000, {sfault, pfault, vout, vin, pump_on});
    @(posedge clk) sol_bad[3] <= 1'b0;
    @(posedge clk) pump_bad <= 2'b01;
    start(3'h1, 3'h3);
    step(12);
    chk("pump_swap", 2'b10, pump_on);
    @(posedge clk) pump_bad <= 2'b11;
    wait_on(1'b0, 20);
    step(3);
    chk("pump_fault", 2'b01, {sfault, pfault});
    @(posedge clk) pump_bad <= 2'b00;
    @(posedge clk)
    begin
      lvl[1] <= 5'h02;
      lvl[4] <= 5'h0c;
    end
    @(posedge clk) disp <= 3'h1;
    step(3);
    chk("alarm", 17'h11212, {aud, talarm, sbell});
    count_bell();
    chk("bell_flash", 1, ones > 0 && ones < 40);
    @(posedge clk) disp <= 3'h2;
    step(2);
    count_bell();
    chk("bell_solid", 40, ones);
    press(MUT);
    chk("muted", 0, aud);
    @(posedge clk) alive[3] <= 1'b0;
    step(3);
    chk("link_lost", 8'h08, lloss);
    @(posedge clk) alive[3] <= 1'b1;
    step(3);
    chk("link_back", 0, lloss);
    press(SEN);
    chk("setup_again", 1, prog);
    @(posedge clk)
    begin
      cfg.alt_mode <= 1'b0;
      cfg.special_en <= 1'b1;
      cfg.special_slot <= 3'h3;
      lvl[1] <= 5'h00;
      lvl[0] <= 5'h04;
    end
    press(SEX);
    wait_on(1'b1, 8);
    chk("single_src", 10'h011, {vout, pump_on});
    @(posedge clk) lvl[0] <= 5'h10;
    wait_on(1'b0, 8);
    start(3'h2, 3'h1);
    chk("special_dst", 8'h08, vin);
    complete_run();
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    complete_run();
  end
endmodule
